//--- i2cb_ctrl.sv
// control register, condition generator and bus watcher of the serial controller
//
// The Wishbone slave port is implemented in this block.
`timescale 1ns/1ps
// Operation
// - prescaler code picks divider from fixed table
// - bit clock is bus clock over divider
// - sample bus lines at prescaler rate
// - enable bit soft-resets controller except prescaler code
// - other control bits need enable set
// - late-enabled slave waits for next START
// - late-enabled master unaware bus busy
// - interrupt enable off keeps pending flag
// - interrupt request when enabled and pending
// - master select rise issues START
// - master select fall issues STOP
// - arbitration loss clears master select silently
// - direction bit: 0 receive, 1 transmit
// - ack value drives ninth-clock data level
// - ack value matters only when receiving
// - repeat start bit writes, reads zero
// - repeat start without bus is loss
// - arbitration lost on busy start
module i2cb_ctrl
(
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [i2cb_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [31:0]               wb_dat_i,
   output logic      [31:0]               wb_dat_o,
   output logic                           wb_ack_o,
   input  wire logic                      scl_i,
   output logic                           scl_o,
   output logic                           scl_oe_o,
   input  wire logic                      sda_i,
   output logic                           sda_o,
   output logic                           sda_oe_o,
   input  wire logic                      ack_slot_i,
   input  wire logic                      byte_done_i,
   input  wire logic                      arb_lost_i,
   input  wire logic                      slave_rw_i,
   output logic                           irq_o,
   output logic                           master_mode_o,
   output logic                           tx_mode_o,
   output logic                           slave_active_o
);
   logic               en_r;
   logic               ien_r;
   logic               msel_r;
   logic               dir_r;
   logic               ackv_r;
   logic [5:0]         fdr_r;
   logic               rs_pend_r;
   logic               busy_r;
   logic               arb_r;
   logic               pend_r;
   logic               slv_r;
   logic               scl_m_r;
   logic               sda_m_r;
   logic               scl_y_r;
   logic               sda_y_r;
   logic               scl_s_r;
   logic               sda_s_r;
   i2cb_pkg::i2cb_cg_t state_r;
   i2cb_pkg::i2cb_cg_t state_nxt;
   logic               soft_rst;
   logic               qtick;
   logic               req;
   logic               wr_hit;
   logic               wr_ctrl;
   logic               wr_fdr;
   logic               wr_stat;
   logic [7:0]         d;
   logic [7:0]         rd_byte;
   logic               arb_set;
   logic               start_det;
   logic               stop_det;
   logic               ack_drv;
   logic               cg_scl;
   logic               cg_sda;
   logic               scl_oe_nxt;
   logic               sda_oe_nxt;

   // bus slave decode
   assign req      = wb_cyc_i & wb_stb_i;
   assign wr_hit   = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wr_ctrl  = wr_hit & (wb_adr_i == i2cb_pkg::CTRL_OFS);
   assign wr_fdr   = wr_hit & (wb_adr_i == i2cb_pkg::FDR_OFS);
   assign wr_stat  = wr_hit & (wb_adr_i == i2cb_pkg::STAT_OFS);
   assign d        = wb_dat_i[7:0];
   assign soft_rst = rst_i | ~en_r;

   assign rd_byte  = (wb_adr_i == i2cb_pkg::FDR_OFS)  ? {2'h0, fdr_r} :
                     (wb_adr_i == i2cb_pkg::CTRL_OFS) ?
                        {en_r, ien_r, msel_r, dir_r, ackv_r, 3'h0} :
                     (wb_adr_i == i2cb_pkg::STAT_OFS) ?
                        {2'h0, busy_r, arb_r, 1'h0, slave_rw_i, pend_r, 1'h0} :
                     8'h00;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= {24'h00_0000, rd_byte};
      end
   end

   i2cb_prescaler u_presc
   (
      .clk_i   (clk_i),
      .rst_i   (soft_rst),
      .code_i  (fdr_r),
      .qtick_o (qtick)
   );

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         fdr_r <= i2cb_pkg::FDR_RST;
      else if (wr_fdr)
         fdr_r <= d[5:0];
   end

   // control bits, all gated by the enable being written
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         en_r   <= 1'b0;
         ien_r  <= 1'b0;
         dir_r  <= 1'b0;
         ackv_r <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         en_r   <= d[i2cb_pkg::C_EN];
         ien_r  <= d[i2cb_pkg::C_EN] & d[i2cb_pkg::C_IEN];
         dir_r  <= d[i2cb_pkg::C_EN] & d[i2cb_pkg::C_DIR];
         ackv_r <= d[i2cb_pkg::C_EN] & d[i2cb_pkg::C_ACKV];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         msel_r <= 1'b0;
      else if (arb_set)
         msel_r <= 1'b0;
      else if (wr_ctrl)
         msel_r <= d[i2cb_pkg::C_EN] & d[i2cb_pkg::C_MSEL];
   end

   always_ff @(posedge clk_i)
   begin
      if (soft_rst | arb_set)
         rs_pend_r <= 1'b0;
      else if (wr_ctrl & d[i2cb_pkg::C_EN] & d[i2cb_pkg::C_REPEAT_START_REQUEST])
         rs_pend_r <= 1'b1;
      else if ((state_r == i2cb_pkg::CG_HOLD) & qtick)
         rs_pend_r <= 1'b0;
   end

   // busy start, repeat start outside ownership, or loss reported by the byte engine
   assign arb_set = en_r & ((msel_r & busy_r & (state_r == i2cb_pkg::CG_IDLE)) |
                    (rs_pend_r & (state_r != i2cb_pkg::CG_HOLD)) |
                    arb_lost_i);

   // line synchronisers and prescaled sampling
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scl_m_r <= 1'b1;
         sda_m_r <= 1'b1;
         scl_y_r <= 1'b1;
         sda_y_r <= 1'b1;
      end
      else
      begin
         scl_m_r <= scl_i;
         sda_m_r <= sda_i;
         scl_y_r <= scl_m_r;
         sda_y_r <= sda_m_r;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (soft_rst)
      begin
         scl_s_r <= 1'b1;
         sda_s_r <= 1'b1;
      end
      else if (qtick)
      begin
         scl_s_r <= scl_y_r;
         sda_s_r <= sda_y_r;
      end
   end

   assign start_det = qtick & scl_s_r & scl_y_r & sda_s_r & ~sda_y_r;
   assign stop_det  = qtick & scl_s_r & scl_y_r & ~sda_s_r & sda_y_r;

   // bus busy and slave arming only learned from conditions seen after enable
   always_ff @(posedge clk_i)
   begin
      if (soft_rst)
      begin
         busy_r <= 1'b0;
         slv_r  <= 1'b0;
      end
      else if (start_det)
      begin
         busy_r <= 1'b1;
         slv_r  <= 1'b1;
      end
      else if (stop_det)
      begin
         busy_r <= 1'b0;
         slv_r  <= 1'b0;
      end
   end

   // status flags: hardware set wins over a software clear
   always_ff @(posedge clk_i)
   begin
      if (soft_rst)
      begin
         arb_r  <= 1'b0;
         pend_r <= 1'b0;
      end
      else
      begin
         if (arb_set)
            arb_r <= 1'b1;
         else if (wr_stat & ~d[i2cb_pkg::S_ARB])
            arb_r <= 1'b0;
         if (arb_set | byte_done_i)
            pend_r <= 1'b1;
         else if (wr_stat & ~d[i2cb_pkg::S_PEND])
            pend_r <= 1'b0;
      end
   end

   // condition generator
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         i2cb_pkg::CG_IDLE:
            if (msel_r & ~busy_r & qtick)
               state_nxt = i2cb_pkg::CG_ST_A;
         i2cb_pkg::CG_ST_A:
            if (qtick)
               state_nxt = i2cb_pkg::CG_ST_B;
         i2cb_pkg::CG_ST_B:
            if (qtick)
               state_nxt = i2cb_pkg::CG_HOLD;
         i2cb_pkg::CG_HOLD:
            if (~msel_r & qtick)
               state_nxt = i2cb_pkg::CG_SP_A;
            else if (rs_pend_r & qtick)
               state_nxt = i2cb_pkg::CG_RS_A;
         i2cb_pkg::CG_RS_A:
            if (qtick)
               state_nxt = i2cb_pkg::CG_RS_B;
         i2cb_pkg::CG_RS_B:
            if (qtick)
               state_nxt = i2cb_pkg::CG_ST_A;
         i2cb_pkg::CG_SP_A:
            if (qtick)
               state_nxt = i2cb_pkg::CG_SP_B;
         i2cb_pkg::CG_SP_B:
            if (qtick)
               state_nxt = i2cb_pkg::CG_SP_C;
         i2cb_pkg::CG_SP_C:
            if (qtick)
               state_nxt = i2cb_pkg::CG_IDLE;
         default:
            state_nxt = i2cb_pkg::CG_IDLE;
      endcase
      if (arb_set)
         state_nxt = i2cb_pkg::CG_IDLE;
   end

   always_ff @(posedge clk_i)
   begin
      if (soft_rst)
         state_r <= i2cb_pkg::CG_IDLE;
      else
         state_r <= state_nxt;
   end

   assign cg_scl  = (state_r == i2cb_pkg::CG_ST_B) | (state_r == i2cb_pkg::CG_HOLD) |
                    (state_r == i2cb_pkg::CG_RS_A) | (state_r == i2cb_pkg::CG_SP_A);
   assign cg_sda  = (state_r == i2cb_pkg::CG_ST_A) | (state_r == i2cb_pkg::CG_ST_B) |
                    (state_r == i2cb_pkg::CG_SP_A) | (state_r == i2cb_pkg::CG_SP_B);
   assign ack_drv = ack_slot_i & ~dir_r & ~ackv_r;
   assign scl_oe_nxt = en_r & cg_scl;
   assign sda_oe_nxt = en_r & (cg_sda | ack_drv);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scl_o          <= 1'b0;
         sda_o          <= 1'b0;
         scl_oe_o       <= 1'b0;
         sda_oe_o       <= 1'b0;
         irq_o          <= 1'b0;
         master_mode_o  <= 1'b0;
         tx_mode_o      <= 1'b0;
         slave_active_o <= 1'b0;
      end
      else
      begin
         scl_o          <= 1'b0;
         sda_o          <= 1'b0;
         scl_oe_o       <= scl_oe_nxt;
         sda_oe_o       <= sda_oe_nxt;
         irq_o          <= ien_r & pend_r;
         master_mode_o  <= msel_r;
         tx_mode_o      <= dir_r;
         slave_active_o <= slv_r;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_start_go;
      en_r && msel_r && !busy_r && state_r == i2cb_pkg::CG_IDLE && qtick && !arb_set;
   endsequence

   chk_irq_follow: assert property (ien_r && pend_r |=> irq_o)
      else $error("irq not raised");
   chk_irq_mask: assert property (en_r && !ien_r && pend_r && !wr_stat
      |=> !irq_o ##0 pend_r)
      else $error("masked irq or lost pending");
   chk_en_reset: assert property (!en_r |=> state_r == i2cb_pkg::CG_IDLE && !busy_r)
      else $error("disabled block not held reset");
   chk_repeat_start_request_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == i2cb_pkg::CTRL_OFS
      |-> !wb_dat_o[i2cb_pkg::C_REPEAT_START_REQUEST] && wb_dat_o[i2cb_pkg::C_EN] == en_r)
      else $error("repeat start bit read nonzero");
   chk_rs_arb: assert property (en_r && rs_pend_r && state_r != i2cb_pkg::CG_HOLD
      |=> arb_r && !msel_r && !rs_pend_r)
      else $error("repeat start without bus not lost");
   chk_start_busy: assert property (en_r && msel_r && busy_r
      && state_r == i2cb_pkg::CG_IDLE |=> arb_r && !msel_r && pend_r)
      else $error("busy start not lost");
   chk_start_issue: assert property (s_start_go |=> state_r == i2cb_pkg::CG_ST_A
      ##1 sda_oe_o && !scl_oe_o)
      else $error("start not driven");
   chk_no_drive_off: assert property (!en_r ##1 !en_r |-> !sda_oe_o && !scl_oe_o)
      else $error("lines driven while disabled");
   chk_ack_level: assert property (en_r && ack_slot_i && !dir_r |=> sda_oe_o == !$past(ackv_r))
      else $error("ack level wrong");
endmodule : i2cb_ctrl

//--- i2cb_pkg.sv
// constants, state type and divider lookup for the serial controller control block
package i2cb_pkg;
   localparam int          ADR_W       = 12;
   localparam int          DIV_W       = 12;
   localparam logic [11:0] FDR_OFS     = 12'h304;
   localparam logic [11:0] CTRL_OFS    = 12'h308;
   localparam logic [11:0] STAT_OFS    = 12'h30c;
   localparam int          C_EN        = 7;
   localparam int          C_IEN       = 6;
   localparam int          C_MSEL      = 5;
   localparam int          C_DIR       = 4;
   localparam int          C_ACKV      = 3;
   localparam int          C_REPEAT_START_REQUEST      = 2;
   localparam int          S_BUSY      = 5;
   localparam int          S_ARB       = 4;
   localparam int          S_SRW       = 2;
   localparam int          S_PEND      = 1;
   localparam logic [5:0]  FDR_RST     = 6'h00;

   typedef enum logic [8:0]
   {
      CG_IDLE = 9'h001,
      CG_ST_A = 9'h002,
      CG_ST_B = 9'h004,
      CG_HOLD = 9'h008,
      CG_RS_A = 9'h010,
      CG_RS_B = 9'h020,
      CG_SP_A = 9'h040,
      CG_SP_B = 9'h080,
      CG_SP_C = 9'h100
   } i2cb_cg_t;

   // prescaler code to bus clock divider
   function automatic logic [11:0] div_of(input logic [5:0] c);
      case (c)
         6'h00: div_of = 12'h01c;
         6'h01: div_of = 12'h01e;
         6'h02: div_of = 12'h022;
         6'h03: div_of = 12'h028;
         6'h04: div_of = 12'h02c;
         6'h05: div_of = 12'h030;
         6'h06: div_of = 12'h038;
         6'h07: div_of = 12'h044;
         6'h08: div_of = 12'h050;
         6'h09: div_of = 12'h058;
         6'h0a: div_of = 12'h068;
         6'h0b: div_of = 12'h080;
         6'h0c: div_of = 12'h090;
         6'h0d: div_of = 12'h0a0;
         6'h0e: div_of = 12'h0c0;
         6'h0f: div_of = 12'h0f0;
         6'h10: div_of = 12'h120;
         6'h11: div_of = 12'h140;
         6'h12: div_of = 12'h180;
         6'h13: div_of = 12'h1e0;
         6'h14: div_of = 12'h240;
         6'h15: div_of = 12'h280;
         6'h16: div_of = 12'h300;
         6'h17: div_of = 12'h3c0;
         6'h18: div_of = 12'h480;
         6'h19: div_of = 12'h500;
         6'h1a: div_of = 12'h600;
         6'h1b: div_of = 12'h780;
         6'h1c: div_of = 12'h900;
         6'h1d: div_of = 12'ha00;
         6'h1e: div_of = 12'hc00;
         6'h1f: div_of = 12'hf00;
         6'h20: div_of = 12'h014;
         6'h21: div_of = 12'h016;
         6'h22: div_of = 12'h018;
         6'h23: div_of = 12'h01a;
         6'h24: div_of = 12'h01c;
         6'h25: div_of = 12'h020;
         6'h26: div_of = 12'h024;
         6'h27: div_of = 12'h028;
         6'h28: div_of = 12'h030;
         6'h29: div_of = 12'h038;
         6'h2a: div_of = 12'h040;
         6'h2b: div_of = 12'h048;
         6'h2c: div_of = 12'h050;
         6'h2d: div_of = 12'h060;
         6'h2e: div_of = 12'h070;
         6'h2f: div_of = 12'h080;
         6'h30: div_of = 12'h0a0;
         6'h31: div_of = 12'h0c0;
         6'h32: div_of = 12'h0e0;
         6'h33: div_of = 12'h100;
         6'h34: div_of = 12'h140;
         6'h35: div_of = 12'h180;
         6'h36: div_of = 12'h1c0;
         6'h37: div_of = 12'h200;
         6'h38: div_of = 12'h280;
         6'h39: div_of = 12'h300;
         6'h3a: div_of = 12'h380;
         6'h3b: div_of = 12'h400;
         6'h3c: div_of = 12'h500;
         6'h3d: div_of = 12'h600;
         6'h3e: div_of = 12'h700;
         6'h3f: div_of = 12'h800;
         default: div_of = 12'h800;
      endcase
   endfunction : div_of
endpackage : i2cb_pkg

//--- i2cb_prescaler.sv
// prescaler: quarter-bit tick from the bus clock and the divider code
`timescale 1ns/1ps
module i2cb_prescaler
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [5:0] code_i,
   output logic            qtick_o
);
   logic [11:0] cnt_r;
   logic [11:0] cnt_nxt;
   logic [11:0] div;
   logic [11:0] q1;
   logic [11:0] q2;
   logic [11:0] q3;
   logic        last;
   logic        qtick_nxt;

   assign div       = i2cb_pkg::div_of(code_i);
   assign last      = (cnt_r >= div - 12'h001);
   assign cnt_nxt   = last ? 12'h000 : cnt_r + 12'h001;
   assign q1        = div >> 2;
   assign q2        = div >> 1;
   assign q3        = q1 + q2;
   assign qtick_nxt = (cnt_r == 12'h000) | (cnt_r == q1) | (cnt_r == q2) | (cnt_r == q3);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_r   <= 12'h000;
         qtick_o <= 1'b0;
      end
      else
      begin
         cnt_r   <= cnt_nxt;
         qtick_o <= qtick_nxt;
      end
   end

   chk_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      qtick_o |=> !qtick_o ##1 !qtick_o)
      else $error("quarter ticks too close");
endmodule : i2cb_prescaler

//--- i2cb_bus_model.sv
// model of another master on the two-wire bus, open drain with pull-ups
`timescale 1ns/1ps
module i2cb_bus_model
(
   input  wire logic clk_i,
   input  wire logic scl_oe_i,
   input  wire logic sda_oe_i,
   output logic      scl_o,
   output logic      sda_o
);
   logic own_scl = 1'b0;
   logic own_sda = 1'b0;

   // released lines float to the pull-up level
   assign scl_o = ~(scl_oe_i | own_scl);
   assign sda_o = ~(sda_oe_i | own_sda);

   task automatic hold();
      repeat (100) @(posedge clk_i);
   endtask : hold

   // start and leave the bus busy with clock low
   task automatic start_cond();
      @(posedge clk_i);
      own_sda <= 1'b1;
      hold();
      own_scl <= 1'b1;
      hold();
   endtask : start_cond

   // release clock, then data, which ends the transfer
   task automatic stop_cond();
      @(posedge clk_i);
      own_scl <= 1'b0;
      hold();
      own_sda <= 1'b0;
      hold();
   endtask : stop_cond
endmodule : i2cb_bus_model

//--- tb.sv
// self-checking testbench of the serial controller control block
`timescale 1ns/1ps
module tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        req = 1'b0, we = 1'b0, ack_slot = 1'b0, byte_done = 1'b0;
   logic        arb_lost = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] dat = 32'h0;
   wire  [31:0] rdat;
   wire         ack, scl, sda, scl_oe, sda_oe, irq, mm, tx, sa;
   wire         scl_lv, sda_lv;
   logic        slave_rw_flag = 1'b0;
   int          error_cnt = 0, compares = 0, seed = 41, n;
   logic [5:0]  c;
   logic [2:0]  b;
   logic [5:0]  codes [4] = '{6'h05, 6'h25, 6'h3f, 6'h20};

   always #5 clk_i = ~clk_i;

   i2cb_ctrl u_i2cb_ctrl
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .scl_i(scl), .scl_o(scl_lv), .scl_oe_o(scl_oe),
      .sda_i(sda), .sda_o(sda_lv), .sda_oe_o(sda_oe),
      .ack_slot_i(ack_slot), .byte_done_i(byte_done), .arb_lost_i(arb_lost),
      .slave_rw_i(slave_rw_flag), .irq_o(irq), .master_mode_o(mm), .tx_mode_o(tx),
      .slave_active_o(sa)
   );

   i2cb_bus_model u_i2cb_bus_model
   (
      .clk_i(clk_i), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda)
   );

   function automatic int div_exp(input logic [5:0] k);
      case (k)
         6'h05: div_exp = 48;
         6'h25: div_exp = 32;
         6'h3f: div_exp = 2048;
         default: div_exp = 20;
      endcase
   endfunction : div_exp

   task automatic close_out();
      $display("mismatches %0d of %0d compares", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r);
      int k;
      k = 0;
      @(posedge clk_i);
      req <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {24'h0, d};
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while (ack !== 1'b1 && k < 100);
      r = rdat;
      req <= 1'b0;
      if (k >= 100)
         error_cnt++;
   endtask : wb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 8'h00, r);
      chk(r & m, e);
   endtask : rdc

   task automatic wt(input bit s, input logic v, output int k);
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end
      while ((s ? scl_oe : sda_oe) !== v && k < 5000);
      if (k >= 5000)
         error_cnt++;
   endtask : wt

   task automatic cyc_n(input int k);
      repeat (k) @(posedge clk_i);
   endtask : cyc_n

   initial
   begin
      #1_000_000;
      error_cnt++;
      close_out();
   end

   initial
   begin
      cyc_n(2);
      rst_i <= 1'b0;
      rdc(i2cb_pkg::CTRL_OFS, 32'hff, 32'h0);
      rdc(i2cb_pkg::FDR_OFS, 32'hff, 32'h0);
      rdc(12'h400, 32'hffffffff, 32'h0);
      wr(i2cb_pkg::CTRL_OFS, 8'h60);
      rdc(i2cb_pkg::CTRL_OFS, 32'hff, 32'h0);
      chk(mm, 1'b0);
      repeat (6)
      begin
         c = 6'($random(seed));
         wr(i2cb_pkg::FDR_OFS, {2'b00, c});
         rdc(i2cb_pkg::FDR_OFS, 32'h3f, {26'h0, c});
      end
      ack_slot <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         b = 3'(i);
         wr(i2cb_pkg::CTRL_OFS, {b[2], 2'b00, b[1], b[0], 3'b000});
         cyc_n(3);
         chk(sda_oe, b[2] & ~b[1] & ~b[0]);
         chk(tx, b[2] & b[1]);
      end
      ack_slot <= 1'b0;
      foreach (codes[i])
      begin
         wr(i2cb_pkg::CTRL_OFS, 8'h00);
         wr(i2cb_pkg::FDR_OFS, {2'b00, codes[i]});
         wr(i2cb_pkg::CTRL_OFS, 8'h80);
         wr(i2cb_pkg::CTRL_OFS, 8'hb0);
         wt(1'b0, 1'b1, n);
         wt(1'b1, 1'b1, n);
         chk(n, div_exp(codes[i]) / 4);
         chk(mm, 1'b1);
         chk(tx, 1'b1);
         chk({scl_lv, sda_lv}, 2'b00);
         rdc(i2cb_pkg::STAT_OFS, 32'h20, 32'h20);
         wr(i2cb_pkg::CTRL_OFS, 8'h80);
         wt(1'b1, 1'b0, n);
         chk(sda_oe, 1'b1);
         wt(1'b0, 1'b0, n);
         cyc_n(div_exp(codes[i]) / 2 + 20);
         rdc(i2cb_pkg::STAT_OFS, 32'h20, 32'h0);
         chk(mm, 1'b0);
      end
      wr(i2cb_pkg::CTRL_OFS, 8'ha0);
      wt(1'b1, 1'b1, n);
      cyc_n(10);
      wr(i2cb_pkg::CTRL_OFS, 8'ha4);
      rdc(i2cb_pkg::CTRL_OFS, 32'hff, 32'ha0);
      wt(1'b1, 1'b0, n);
      wt(1'b0, 1'b1, n);
      wt(1'b1, 1'b1, n);
      chk(mm, 1'b1);
      rdc(i2cb_pkg::STAT_OFS, 32'h10, 32'h0);
      @(posedge clk_i);
      arb_lost <= 1'b1;
      @(posedge clk_i);
      arb_lost <= 1'b0;
      cyc_n(2);
      chk({scl_oe, sda_oe, mm}, 3'b000);
      rdc(i2cb_pkg::CTRL_OFS, 32'h20, 32'h0);
      cyc_n(50);
      wr(i2cb_pkg::STAT_OFS, 8'h00);
      wr(i2cb_pkg::CTRL_OFS, 8'h84);
      rdc(i2cb_pkg::STAT_OFS, 32'h12, 32'h12);
      chk({mm, sda_oe}, 2'b00);
      wr(i2cb_pkg::CTRL_OFS, 8'hc0);
      cyc_n(2);
      chk(irq, 1'b1);
      wr(i2cb_pkg::CTRL_OFS, 8'h80);
      cyc_n(2);
      chk(irq, 1'b0);
      rdc(i2cb_pkg::STAT_OFS, 32'h02, 32'h02);
      wr(i2cb_pkg::STAT_OFS, 8'h00);
      rdc(i2cb_pkg::STAT_OFS, 32'h12, 32'h0);
      @(posedge clk_i);
      byte_done <= 1'b1;
      @(posedge clk_i);
      byte_done <= 1'b0;
      rdc(i2cb_pkg::STAT_OFS, 32'h02, 32'h02);
      wr(i2cb_pkg::STAT_OFS, 8'h00);
      u_i2cb_bus_model.start_cond();
      wr(i2cb_pkg::CTRL_OFS, 8'ha0);
      cyc_n(3);
      chk({mm, sda_oe}, 2'b00);
      rdc(i2cb_pkg::STAT_OFS, 32'h10, 32'h10);
      u_i2cb_bus_model.stop_cond();
      wr(i2cb_pkg::STAT_OFS, 8'h00);
      wr(i2cb_pkg::CTRL_OFS, 8'ha0);
      wt(1'b1, 1'b1, n);
      wr(i2cb_pkg::CTRL_OFS, 8'h00);
      cyc_n(3);
      chk({scl_oe, sda_oe, mm}, 3'b000);
      rdc(i2cb_pkg::FDR_OFS, 32'h3f, 32'h20);
      u_i2cb_bus_model.start_cond();
      wr(i2cb_pkg::CTRL_OFS, 8'h80);
      cyc_n(20);
      chk(sa, 1'b0);
      u_i2cb_bus_model.stop_cond();
      u_i2cb_bus_model.start_cond();
      chk(sa, 1'b1);
      slave_rw_flag <= 1'($random(seed));
      @(posedge clk_i);
      rdc(i2cb_pkg::STAT_OFS, 32'h04, {29'h0, slave_rw_flag, 2'b00});
      wr(i2cb_pkg::CTRL_OFS, {3'b100, slave_rw_flag, 4'h0});
      cyc_n(2);
      chk(tx, slave_rw_flag);
      u_i2cb_bus_model.stop_cond();
      chk(sa, 1'b0);
      close_out();
   end
endmodule : tb
